// file: logic/serial_port.sv
// Operation
// RQ1: Internal bit clock period is (1 + divider) CPU clock periods; a divider of 0 is run as 1, giving 2 periods.
// RQ2: Low phase is half period for odd divider, divider/2 periods when even.
// RQ3: High phase is half period for odd divider, divider/2+1 periods when even.
// RQ4: A set polarity bit inverts its clock or frame sync and all edge references.
// RQ5: Receive data is sampled on the falling receive bit clock edge.
// RQ6: External receive frame sync is sampled on the falling receive clock edge.
// RQ7: External transmit frame sync is sampled on the falling transmit clock edge.
// RQ8: Internal frame syncs update on the rising edge of their bit clock.
// RQ9: All transmit bits except the first launch on the rising clock edge.
// RQ10: With one or two bit delay the first bit launches on a rising edge.
// RQ11: With zero delay the first bit is driven directly from the frame sync edge.
// RQ12: The enable delay option postpones driving the first bit by 4H.
// RQ13: After the last bit the output goes high impedance on the next rising edge.
// RQ14: External clock and sync pins are inputs, synchronised before use.
`timescale 1ns/1ps
`default_nettype none
module serial_port #(
	parameter int WORD_BITS = sport_pkg::WORD_BITS,
	parameter int FRAME_BITS = sport_pkg::FRAME_BITS,
	parameter int FIFO_DEPTH = sport_pkg::FIFO_DEPTH
) (
	input wire logic mclk,
	input wire logic srst,
	input wire sport_pkg::port_cfg_t cfg,
	input wire logic [WORD_BITS-1:0] tx_word,
	input wire logic tx_word_valid,
	output logic tx_word_ready,
	output logic [WORD_BITS-1:0] rx_word,
	output logic rx_word_valid,
	output logic tx_underrun,
	input wire logic rx_bit_clock_i,
	output logic rx_bit_clock_o,
	output logic rx_bit_clock_oe,
	input wire logic tx_bit_clock_i,
	output logic tx_bit_clock_o,
	output logic tx_bit_clock_oe,
	input wire logic rx_frame_sync_i,
	output logic rx_frame_sync_o,
	output logic rx_frame_sync_oe,
	input wire logic tx_frame_sync_i,
	output logic tx_frame_sync_o,
	output logic tx_frame_sync_oe,
	input wire logic serial_in_line,
	output logic serial_out_line,
	output logic serial_out_line_oe
);
	localparam int DW = sport_pkg::DIV_W;
	localparam int CW = $clog2(WORD_BITS);
	localparam int FW = $clog2(FRAME_BITS);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [sport_pkg::PIN_N-1:0] s1_r;
	logic [sport_pkg::PIN_N-1:0] s2_r;
	logic [sport_pkg::PIN_N-1:0] s3_r;
	wire [sport_pkg::PIN_N-1:0] pins = {serial_in_line, tx_frame_sync_i, rx_frame_sync_i,
		tx_bit_clock_i, rx_bit_clock_i};

	// RQ14: two-stage sync
	// Two stages per pin; the third stage only feeds edge detection.
	always_ff @(posedge mclk)
	begin
		s1_r <= pins;
		s2_r <= s1_r;
		s3_r <= s2_r;
	end

	// ------------------------------------------------------------
	// Internal bit clock divider
	// ------------------------------------------------------------
	logic clkg_r;
	logic clkg_d_r;
	logic [DW-1:0] ph_r;
	wire [DW-1:0] div_eff = (cfg.bit_clock_divider == '0) ? DW'(1) : cfg.bit_clock_divider;
	// RQ2: low phase length
	wire [DW-1:0] lo_len = (div_eff >> 1) + DW'(div_eff[0]);
	// RQ3: high phase length
	wire [DW-1:0] hi_len = (div_eff >> 1) + DW'(1);

	// RQ1: period from both phases
	// Each phase counts down; the next phase length loads at the toggle.
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			clkg_r <= 1'b0;
			clkg_d_r <= 1'b0;
			ph_r <= '0;
		end
		else
		begin
			clkg_d_r <= clkg_r;
			if (ph_r == '0)
			begin
				clkg_r <= !clkg_r;
				ph_r <= clkg_r ? lo_len - DW'(1) : hi_len - DW'(1);
			end
			else
				ph_r <= ph_r - DW'(1);
		end
	end

	// ------------------------------------------------------------
	// Edge and frame sync decoding
	// ------------------------------------------------------------
	// RQ4: polarity correction
	// Clock levels seen with the polarity removed, now and one cycle earlier.
	wire rx_now = cfg.rx_clock_internal ? clkg_r : s2_r[sport_pkg::PIN_RXC] ^ cfg.rx_clock_polarity;
	wire rx_prev = cfg.rx_clock_internal ? clkg_d_r : s3_r[sport_pkg::PIN_RXC] ^ cfg.rx_clock_polarity;
	wire tx_now = cfg.tx_clock_internal ? clkg_r : s2_r[sport_pkg::PIN_TXC] ^ cfg.tx_clock_polarity;
	wire tx_prev = cfg.tx_clock_internal ? clkg_d_r : s3_r[sport_pkg::PIN_TXC] ^ cfg.tx_clock_polarity;
	wire rx_rise = rx_now && !rx_prev;
	wire rx_fall = !rx_now && rx_prev;
	wire tx_rise = tx_now && !tx_prev;
	wire tx_fall = !tx_now && tx_prev;

	logic rx_fs_r;
	logic tx_fs_r;
	logic [FW-1:0] rx_fcnt_r;
	logic [FW-1:0] tx_fcnt_r;
	sport_pkg::tx_state_t tx_state_r;
	sport_pkg::rx_state_t rx_state_r;
	logic fifo_valid;
	logic [WORD_BITS-1:0] fifo_data;

	// Frame sync levels with the polarity removed.
	wire rx_fs_act = cfg.rx_sync_internal ? rx_fs_r : s2_r[sport_pkg::PIN_RXF] ^ cfg.rx_sync_polarity;
	wire tx_fs_ext = s2_r[sport_pkg::PIN_TXF] ^ cfg.tx_sync_polarity;
	wire tx_fs_ext_d = s3_r[sport_pkg::PIN_TXF] ^ cfg.tx_sync_polarity;
	wire tx_fs_act = cfg.tx_sync_internal ? tx_fs_r : tx_fs_ext;
	// An internal transmit frame starts only when a word is waiting.
	wire tx_fs_set = tx_rise && (tx_fcnt_r == '0) && fifo_valid && (tx_state_r == sport_pkg::TX_IDLE);
	wire tx_fs_edge = cfg.tx_sync_internal ? tx_fs_set : (tx_fs_ext && !tx_fs_ext_d);

	// RQ8: syncs move on rising edges
	// Internal frame syncs are one bit wide; receive gives one per frame period, transmit one only in frames where a word is waiting.
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			rx_fs_r <= 1'b0;
			tx_fs_r <= 1'b0;
			rx_fcnt_r <= '0;
			tx_fcnt_r <= '0;
		end
		else
		begin
			if (rx_rise)
			begin
				rx_fs_r <= (rx_fcnt_r == '0);
				rx_fcnt_r <= (rx_fcnt_r == FW'(FRAME_BITS - 1)) ? '0 : rx_fcnt_r + FW'(1);
			end
			if (tx_rise)
			begin
				tx_fs_r <= tx_fs_set;
				tx_fcnt_r <= (tx_fcnt_r == FW'(FRAME_BITS - 1)) ? '0 : tx_fcnt_r + FW'(1);
			end
		end
	end

	// RQ14: outputs only when internal
	// Pin drivers put the polarity back on.
	assign rx_bit_clock_o = clkg_r ^ cfg.rx_clock_polarity;
	assign tx_bit_clock_o = clkg_r ^ cfg.tx_clock_polarity;
	assign rx_frame_sync_o = rx_fs_r ^ cfg.rx_sync_polarity;
	assign tx_frame_sync_o = tx_fs_r ^ cfg.tx_sync_polarity;
	assign rx_bit_clock_oe = cfg.rx_clock_internal;
	assign tx_bit_clock_oe = cfg.tx_clock_internal;
	assign rx_frame_sync_oe = cfg.rx_sync_internal;
	assign tx_frame_sync_oe = cfg.tx_sync_internal;

	// ------------------------------------------------------------
	// Transmitter
	// ------------------------------------------------------------
	logic [WORD_BITS-1:0] tx_sr_r;
	logic [CW-1:0] tx_cnt_r;
	logic [1:0] tx_wait_r;
	logic [1:0] oe_wait_r;
	logic tx_out_r;
	logic underrun_r;

	// RQ11: zero delay starts on sync edge
	wire tx_start0 = (tx_state_r == sport_pkg::TX_IDLE) && (cfg.tx_first_bit_delay == sport_pkg::DLY_ZERO)
		&& tx_fs_edge;
	// RQ7: sync sampled on falling edge
	wire tx_sample = (tx_state_r == sport_pkg::TX_IDLE) && (cfg.tx_first_bit_delay != sport_pkg::DLY_ZERO)
		&& tx_fall && tx_fs_act;
	// RQ10: delayed first bit on a rising edge
	wire tx_launch_d = (tx_state_r == sport_pkg::TX_ARM) && tx_rise && (tx_wait_r == 2'h1);
	wire tx_launch = tx_start0 || tx_launch_d;
	wire fifo_pop = tx_launch && fifo_valid;

	word_fifo #(
		.WIDTH(WORD_BITS),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.mclk(mclk),
		.srst(srst),
		.in_data(tx_word),
		.in_valid(tx_word_valid),
		.in_ready(tx_word_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop)
	);

	// RQ13: release line after last bit
	// The line is driven only while shifting, once the enable delay has run out.
	assign serial_out_line_oe = (tx_state_r == sport_pkg::TX_SHIFT) && (oe_wait_r == 2'h0);
	assign serial_out_line = tx_out_r;
	assign tx_underrun = underrun_r;

	// Transmit sequencing: arm, launch, shift, release.
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			tx_state_r <= sport_pkg::TX_IDLE;
			tx_sr_r <= '0;
			tx_cnt_r <= '0;
			tx_wait_r <= '0;
			oe_wait_r <= '0;
			tx_out_r <= 1'b0;
			underrun_r <= 1'b0;
		end
		else
		begin
			underrun_r <= tx_launch && !fifo_valid;
			if (oe_wait_r != 2'h0)
				oe_wait_r <= oe_wait_r - 2'h1;
			if (fifo_pop)
			begin
				tx_state_r <= sport_pkg::TX_SHIFT;
				tx_sr_r <= fifo_data;
				tx_out_r <= fifo_data[WORD_BITS-1];
				tx_cnt_r <= CW'(WORD_BITS - 1);
				// RQ12: postpone first drive
				oe_wait_r <= cfg.out_enable_extra_delay ? 2'(sport_pkg::OE_EXTRA_CYC) : 2'h0;
			end
			else if (tx_launch)
				tx_state_r <= sport_pkg::TX_IDLE;
			else if (tx_sample)
			begin
				tx_state_r <= sport_pkg::TX_ARM;
				tx_wait_r <= cfg.tx_first_bit_delay;
			end
			else if (tx_state_r == sport_pkg::TX_ARM && tx_rise)
				tx_wait_r <= tx_wait_r - 2'h1;
			else if (tx_state_r == sport_pkg::TX_SHIFT && tx_rise)
			begin
				// RQ9: later bits on rising edge
				if (tx_cnt_r == '0)
					tx_state_r <= sport_pkg::TX_IDLE;
				else
				begin
					tx_sr_r <= {tx_sr_r[WORD_BITS-2:0], 1'b0};
					tx_out_r <= tx_sr_r[WORD_BITS-2];
					tx_cnt_r <= tx_cnt_r - CW'(1);
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Receiver
	// ------------------------------------------------------------
	logic [WORD_BITS-1:0] rx_sr_r;
	logic [CW-1:0] rx_cnt_r;
	logic [1:0] rx_wait_r;
	logic [WORD_BITS-1:0] rx_word_r;
	logic rx_valid_r;
	wire rx_bit = s2_r[sport_pkg::PIN_DIN];
	// RQ6: sync sampled on falling edge
	wire rx_start = (rx_state_r == sport_pkg::RX_IDLE) && rx_fall && rx_fs_act;
	wire rx_cap = rx_fall && ((rx_start && cfg.rx_first_bit_delay == sport_pkg::DLY_ZERO)
		|| (rx_state_r == sport_pkg::RX_WAIT && rx_wait_r == 2'h1) || rx_state_r == sport_pkg::RX_SHIFT);

	assign rx_word = rx_word_r;
	assign rx_word_valid = rx_valid_r;

	// RQ5: capture on falling edge
	// Bits shift in MSB first; a full word is handed out as a one-cycle pulse.
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			rx_state_r <= sport_pkg::RX_IDLE;
			rx_sr_r <= '0;
			rx_cnt_r <= '0;
			rx_wait_r <= '0;
			rx_word_r <= '0;
			rx_valid_r <= 1'b0;
		end
		else
		begin
			rx_valid_r <= 1'b0;
			if (rx_cap)
				rx_sr_r <= {rx_sr_r[WORD_BITS-2:0], rx_bit};
			if (rx_cap && rx_state_r != sport_pkg::RX_SHIFT)
			begin
				rx_state_r <= sport_pkg::RX_SHIFT;
				rx_cnt_r <= CW'(WORD_BITS - 1);
			end
			else if (rx_cap)
			begin
				rx_cnt_r <= rx_cnt_r - CW'(1);
				if (rx_cnt_r == CW'(1))
				begin
					rx_state_r <= sport_pkg::RX_IDLE;
					rx_word_r <= {rx_sr_r[WORD_BITS-2:0], rx_bit};
					rx_valid_r <= 1'b1;
				end
			end
			else if (rx_start)
			begin
				rx_state_r <= sport_pkg::RX_WAIT;
				rx_wait_r <= cfg.rx_first_bit_delay;
			end
			else if (rx_state_r == sport_pkg::RX_WAIT && rx_fall)
				rx_wait_r <= rx_wait_r - 2'h1;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);

	logic [DW:0] per_r;
	logic [DW:0] ph_cnt_r;
	logic [1:0] eg_r;
	logic [DW-1:0] div_d_r;
	wire int_rise = clkg_r && !clkg_d_r;
	wire int_fall = !clkg_r && clkg_d_r;

	// Helper counters measure the internal clock after the divider settles.
	always_ff @(posedge mclk)
	begin
		div_d_r <= cfg.bit_clock_divider;
		if (srst || div_d_r != cfg.bit_clock_divider)
			eg_r <= 2'h0;
		else if ((int_rise || int_fall) && eg_r != 2'h3)
			eg_r <= eg_r + 2'h1;
		per_r <= int_rise ? '0 : per_r + (DW+1)'(1);
		ph_cnt_r <= (int_rise || int_fall) ? '0 : ph_cnt_r + (DW+1)'(1);
	end

	property p_period;
		int_rise && eg_r == 2'h3 |-> per_r == (DW+1)'(div_eff);
	endproperty
	a_period: assert property (p_period) else $error("bit clock period wrong"); // RQ1
	property p_low;
		int_rise && eg_r == 2'h3 |-> ph_cnt_r == (DW+1)'(lo_len - DW'(1));
	endproperty
	a_low: assert property (p_low) else $error("bit clock low phase wrong"); // RQ2
	property p_high;
		int_fall && eg_r == 2'h3 |-> ph_cnt_r == (DW+1)'(hi_len - DW'(1));
	endproperty
	a_high: assert property (p_high) else $error("bit clock high phase wrong"); // RQ3
	property p_pol;
		cfg.rx_clock_internal && rx_rise |-> rx_bit_clock_o == !cfg.rx_clock_polarity;
	endproperty
	a_pol: assert property (p_pol) else $error("rx clock polarity wrong"); // RQ4
	property p_rx_sample;
		rx_word_valid |-> $past(rx_fall);
	endproperty
	a_rx_sample: assert property (p_rx_sample) else $error("rx word not on falling edge"); // RQ5
	property p_rx_sync;
		$past(rx_state_r == sport_pkg::RX_IDLE) && rx_state_r != sport_pkg::RX_IDLE |-> $past(rx_fall && rx_fs_act);
	endproperty
	a_rx_sync: assert property (p_rx_sync) else $error("rx frame not started on falling edge"); // RQ6
	property p_tx_sync;
		$rose(tx_state_r == sport_pkg::TX_ARM) |-> $past(tx_fall && tx_fs_act);
	endproperty
	a_tx_sync: assert property (p_tx_sync) else $error("tx sync not sampled on falling edge"); // RQ7
	property p_fs_update;
		$changed(tx_fs_r) |-> $past(tx_rise);
	endproperty
	a_fs_update: assert property (p_fs_update) else $error("tx frame sync moved off rising edge"); // RQ8
	property p_shift;
		tx_state_r == sport_pkg::TX_SHIFT && $past(tx_state_r == sport_pkg::TX_SHIFT) && $changed(tx_out_r)
			|-> $past(tx_rise || fifo_pop);
	endproperty
	a_shift: assert property (p_shift) else $error("tx bit moved off rising edge"); // RQ9
	property p_first_dly;
		$past(tx_state_r == sport_pkg::TX_ARM) && tx_state_r == sport_pkg::TX_SHIFT |-> $past(tx_rise);
	endproperty
	a_first_dly: assert property (p_first_dly) else $error("delayed first bit off rising edge"); // RQ10
	property p_first0;
		tx_start0 && fifo_valid |=> tx_state_r == sport_pkg::TX_SHIFT && tx_out_r == $past(fifo_data[WORD_BITS-1]);
	endproperty
	a_first0: assert property (p_first0) else $error("zero delay first bit not driven"); // RQ11
	property p_oe_extra;
		fifo_pop && cfg.out_enable_extra_delay && $stable(cfg) |=> !serial_out_line_oe [*2] ##1 serial_out_line_oe;
	endproperty
	a_oe_extra: assert property (p_oe_extra) else $error("extra enable delay wrong"); // RQ12
	property p_release;
		tx_state_r == sport_pkg::TX_SHIFT && tx_cnt_r == '0 && tx_rise && !fifo_pop |=> !serial_out_line_oe;
	endproperty
	a_release: assert property (p_release) else $error("line not released after last bit"); // RQ13
	property p_ext_sync;
		!cfg.rx_clock_internal && rx_fall && $stable(cfg) |-> !($past(rx_bit_clock_i, 2) ^ cfg.rx_clock_polarity);
	endproperty
	a_ext_sync: assert property (p_ext_sync) else $error("external clock not synchronised"); // RQ14

	c_start0: cover property (tx_start0 && fifo_valid);
	c_rx_word: cover property (rx_word_valid);
	c_oe_extra: cover property (fifo_pop && cfg.out_enable_extra_delay);
endmodule
`default_nettype wire

// file: logic/sport_pkg.sv
`default_nettype none
// ------------------------------------------------------------
// Shared constants and types of the serial port.
// ------------------------------------------------------------
package sport_pkg;

	// CPU clock period; one period equals 2H.
	localparam int CLK_PERIOD_NS = 10;
	// Extra output-enable delay of the first bit (4H).
	localparam int OE_EXTRA_NS = 20;
	localparam int OE_EXTRA_CYC = (OE_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Default sizes.
	localparam int DIV_W = 8;
	localparam int WORD_BITS = 16;
	localparam int FRAME_BITS = 32;
	localparam int FIFO_DEPTH = 16;

	// First bit delay encodings.
	localparam logic [1:0] DLY_ZERO = 2'h0;
	localparam logic [1:0] DLY_ONE = 2'h1;
	localparam logic [1:0] DLY_TWO = 2'h2;

	// Positions of the synchronised pins.
	localparam int PIN_RXC = 0;
	localparam int PIN_TXC = 1;
	localparam int PIN_RXF = 2;
	localparam int PIN_TXF = 3;
	localparam int PIN_DIN = 4;
	localparam int PIN_N = 5;

	// Static configuration of the port.
	typedef struct packed {
		logic [DIV_W-1:0] bit_clock_divider;
		logic rx_clock_polarity;
		logic tx_clock_polarity;
		logic rx_sync_polarity;
		logic tx_sync_polarity;
		logic rx_clock_internal;
		logic tx_clock_internal;
		logic rx_sync_internal;
		logic tx_sync_internal;
		logic [1:0] rx_first_bit_delay;
		logic [1:0] tx_first_bit_delay;
		logic out_enable_extra_delay;
	} port_cfg_t;

	typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_ARM = 2'b01, TX_SHIFT = 2'b10} tx_state_t;
	typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_WAIT = 2'b01, RX_SHIFT = 2'b10} rx_state_t;

endpackage
`default_nettype wire

// file: logic/word_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Synchronous FIFO with valid/ready on both sides.
// ------------------------------------------------------------
module word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0] fill_r;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// Full and empty follow the fill level directly.
	assign in_ready = (fill_r != (AW+1)'(DEPTH));
	assign out_valid = (fill_r != '0);
	assign out_data = mem[rd_r];

	// Storage array write port.
	always_ff @(posedge mclk)
	begin
		if (push)
			mem[wr_r] <= in_data;
	end

	// Pointers wrap at the depth.
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			wr_r <= '0;
			rd_r <= '0;
			fill_r <= '0;
		end
		else
		begin
			if (push)
				wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
			if (pop)
				rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
			if (push && !pop)
				fill_r <= fill_r + 1'b1;
			else if (pop && !push)
				fill_r <= fill_r - 1'b1;
		end
	end
endmodule
`default_nettype wire

// file: verification/codec_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Far-end codec: free bit clock, syncs, capture and data source.
// ------------------------------------------------------------
module codec_model (
	input wire logic mclk,
	input wire logic srst,
	input wire sport_pkg::port_cfg_t cfg,
	input wire logic run,
	input wire logic txc,
	input wire logic rxc,
	input wire logic txf,
	input wire logic rxf,
	input wire logic dx,
	input wire logic dx_oe,
	output logic m_txc,
	output logic m_rxc,
	output logic m_txf,
	output logic m_rxf,
	output logic din,
	output logic [15:0] got,
	output logic got_v,
	output logic [15:0] sent,
	output logic sent_v,
	output logic fault
);
	logic mc = 1'b0;
	logic fs = 1'b0;
	logic pt = 1'b0;
	logic pr = 1'b0;
	logic busy = 1'b0;
	logic [15:0] rw = 16'hB5C3;
	int fc = 0;
	int tcnt = 0;
	int tn = 0;
	int ton = 0;
	int rcnt = 63;
	int idx = 0;
	wire tcl = txc ^ cfg.tx_clock_polarity;
	wire rcl = rxc ^ cfg.rx_clock_polarity;
	wire tfs = txf ^ cfg.tx_sync_polarity;
	wire rfs = rxf ^ cfg.rx_sync_polarity;
	// Pins carry the active-high levels turned by the polarity bits.
	assign m_txc = mc ^ cfg.tx_clock_polarity;
	assign m_rxc = mc ^ cfg.rx_clock_polarity;
	assign m_txf = fs ^ cfg.tx_sync_polarity;
	assign m_rxf = fs ^ cfg.rx_sync_polarity;
	initial din = 1'b0;
	// sync at rise
	// The clock stands still while run is low; one-bit sync every 32 bits.
	// Pin edges fall on the falling mclk edge, so no flop races with them.
	always
	begin
		repeat (9) @(negedge mclk);
		if (run)
		begin
			mc = ~mc;
			if (mc)
			begin
				fc = (fc + 1) % 32;
				fs = (fc == 0);
			end
		end
	end
	// idle after word
	// Words are taken on falling edges; a half-driven word is a fault.
	always @(posedge mclk)
	begin
		got_v <= 1'b0;
		fault <= 1'b0;
		if (srst)
			busy = 1'b0;
		else if (pt && !tcl)
		begin
			if (tfs && !busy)
			begin
				busy = 1'b1;
				tcnt = 0;
				tn = 0;
				ton = 0;
			end
			else
				tcnt++;
			if (busy && tcnt >= int'(cfg.tx_first_bit_delay))
			begin
				if (tn == 16)
				begin
					busy = 1'b0;
					fault <= dx_oe || (ton != 0 && ton != 16);
					got_v <= (ton == 16);
				end
				else
				begin
					got <= {got[14:0], dx};
					ton += dx_oe;
					tn++;
				end
			end
		end
		pt = tcl;
	end
	// data at rise
	// Data changes on rising edges; outside a word the line keeps toggling.
	always @(posedge mclk)
	begin
		sent_v <= 1'b0;
		if (srst)
			rcnt = 63;
		else if (pr && !rcl)
			rcnt = rfs ? 0 : (rcnt < 63 ? rcnt + 1 : 63);
		else if (!pr && rcl)
		begin
			idx = rcnt + 1 - int'(cfg.rx_first_bit_delay);
			if (idx == 0)
				rw = (rw << 3) ^ (rw >> 5) ^ 16'h6D2B;
			din <= (idx >= 0 && idx < 16) ? rw[15 - idx] : ~din;
			if (idx == 15)
			begin
				sent <= rw;
				sent_v <= 1'b1;
			end
		end
		pr = rcl;
	end
endmodule
`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Bench of the serial port against the codec model.
// ------------------------------------------------------------
module tb;
	sport_pkg::port_cfg_t cfg = '0;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic run = 1'b0;
	logic tx_word_valid = 1'b0;
	logic [15:0] tx_word = 16'h0000;
	logic [15:0] rx_word, got, sent;
	logic tx_word_ready, rx_word_valid, tx_underrun, got_v, sent_v, fault, din;
	logic rxc_o, rxc_oe, txc_o, txc_oe, rxf_o, rxf_oe, txf_o, txf_oe, dout, dout_oe;
	logic m_rxc, m_txc, m_rxf, m_txf, ptc, prf;
	logic poe = 1'b0;
	logic [15:0] txq[$];
	logic [15:0] rxq[$];
	int fails = 0;
	int compares = 0;
	int seed = 32'h274EA98E;
	int cyc = 0;
	int n_und = 0;
	int since = 0;
	int lat = 0;
	// Each pin shows whichever party enables it.
	wire rxc = rxc_oe ? rxc_o : m_rxc;
	wire txc = txc_oe ? txc_o : m_txc;
	wire rxf = rxf_oe ? rxf_o : m_rxf;
	wire txf = txf_oe ? txf_o : m_txf;
	wire tcl = txc ^ cfg.tx_clock_polarity;
	wire rcl = rxc ^ cfg.rx_clock_polarity;

	serial_port i_serial_port (.mclk(mclk), .srst(srst), .cfg(cfg), .tx_word(tx_word),
		.tx_word_valid(tx_word_valid), .tx_word_ready(tx_word_ready), .rx_word(rx_word),
		.rx_word_valid(rx_word_valid), .tx_underrun(tx_underrun), .rx_bit_clock_i(rxc),
		.rx_bit_clock_o(rxc_o), .rx_bit_clock_oe(rxc_oe), .tx_bit_clock_i(txc), .tx_bit_clock_o(txc_o),
		.tx_bit_clock_oe(txc_oe), .rx_frame_sync_i(rxf), .rx_frame_sync_o(rxf_o), .rx_frame_sync_oe(rxf_oe),
		.tx_frame_sync_i(txf), .tx_frame_sync_o(txf_o), .tx_frame_sync_oe(txf_oe), .serial_in_line(din),
		.serial_out_line(dout), .serial_out_line_oe(dout_oe));
	codec_model i_codec_model (.mclk(mclk), .srst(srst), .cfg(cfg), .run(run), .txc(txc), .rxc(rxc),
		.txf(txf), .rxf(rxf), .dx(dout), .dx_oe(dout_oe), .m_txc(m_txc), .m_rxc(m_rxc), .m_txf(m_txf),
		.m_rxf(m_rxf), .din(din), .got(got), .got_v(got_v), .sent(sent), .sent_v(sent_v), .fault(fault));

	// The clock runs at 100 MHz.
	always #5 mclk = ~mclk;

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic conclude();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// A failed check is counted and reported at once.
	task automatic chk(input logic ok, input string what);
		compares++;
		if (ok !== 1'b1)
		begin
			fails++;
			$display("BAD %0t %s", $time, what);
		end
	endtask

	// Configuration changes only inside a reset, so no frame is cut.
	task automatic restart(input sport_pkg::port_cfg_t c);
		srst <= 1'b1;
		run <= 1'b0;
		cfg <= c;
		repeat (3) @(posedge mclk);
		txq.delete();
		rxq.delete();
		n_und = 0;
		srst <= 1'b0;
	endtask

	// Offers random words until n are taken or the tries run out.
	task automatic offer(input int n, output int k);
		logic [15:0] w;
		logic t;
		k = 0;
		tx_word_valid <= 1'b1;
		for (int i = 0; i < 400 && k < n; i++)
		begin
			w = 16'($random(seed));
			tx_word <= w;
			// Ready is settled at the falling edge and holds until the taking edge.
			@(negedge mclk);
			t = tx_word_ready;
			@(posedge mclk);
			if (t === 1'b1)
			begin
				txq.push_back(w);
				k++;
			end
		end
		tx_word_valid <= 1'b0;
	endtask

	// Counts high and low cycles of the raw transmit clock pin.
	task automatic meas(output int hi, output int lo);
		hi = 0;
		lo = 0;
		while (txc_o !== 1'b0) @(posedge mclk);
		while (txc_o === 1'b0) @(posedge mclk);
		while (txc_o === 1'b1)
		begin
			hi++;
			@(posedge mclk);
		end
		while (txc_o === 1'b0)
		begin
			lo++;
			@(posedge mclk);
		end
	endtask

	// Words are matched at both ends; enable latency and sync edges are followed.
	always @(posedge mclk)
	begin
		cyc++;
		if (got_v === 1'b1)
		begin
			chk(txq.size() > 0 && got === txq[0], "transmit word");
			if (txq.size() > 0)
				void'(txq.pop_front());
		end
		if (sent_v === 1'b1)
			rxq.push_back(sent);
		if (rx_word_valid === 1'b1)
		begin
			chk(rxq.size() > 0 && rx_word === rxq[0], "receive word");
			if (rxq.size() > 0)
				void'(rxq.pop_front());
		end
		if (fault === 1'b1)
			chk(1'b0, "line enable");
		if (srst === 1'b0 && rxf_o !== prf && rxf_oe === 1'b1 && cfg.bit_clock_divider > 8'h04)
			chk(rcl === 1'b1, "sync update edge");
		n_und += (tx_underrun === 1'b1);
		if (dout_oe === 1'b1 && poe === 1'b0)
			lat = since;
		since = (tcl === 1'b1 && ptc === 1'b0) ? 0 : since + 1;
		poe = dout_oe;
		ptc = tcl;
		prf = rxf_o;
		if (cyc == 60000)
		begin
			fails++;
			$display("BAD %0t run too long", $time);
			conclude();
		end
	end

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial
	begin
		sport_pkg::port_cfg_t c;
		int h, l, e, k, l0, eh;
		logic [7:0] dv[6] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h06, 8'h09};
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		// Divider table then random dividers, both transmit clock polarities.
		for (int i = 0; i < 16; i++)
		begin
			c = '0;
			c.bit_clock_divider = i < 12 ? dv[i / 2] : 8'($random(seed)) & 8'h1F;
			c.tx_clock_polarity = i[0];
			{c.tx_clock_internal, c.rx_clock_internal} = 2'h3;
			restart(c);
			meas(h, l);
			e = c.bit_clock_divider == 8'h00 ? 1 : int'(c.bit_clock_divider);
			eh = i[0] ? e + 1 - (e / 2 + 1) : e / 2 + 1;
			chk(h == eh && h + l == e + 1, "clock phases");
			chk(txc_oe === 1'b1 && txf_oe === 1'b0, "pin enables");
		end
		$display("test divider done");
		// Internal clocks and syncs: every transmit delay, receive delays one and two, with and without the enable delay.
		for (int i = 0; i < 6; i++)
		begin
			c = '0;
			c.bit_clock_divider = 8'h09;
			{c.rx_clock_internal, c.tx_clock_internal, c.rx_sync_internal, c.tx_sync_internal} = 4'hF;
			c.tx_first_bit_delay = 2'(i / 2);
			c.rx_first_bit_delay = i < 2 ? 2'h1 : 2'(i / 2);
			c.out_enable_extra_delay = i[0];
			{c.tx_clock_polarity, c.rx_sync_polarity} = {2{i[0]}};
			{c.rx_clock_polarity, c.tx_sync_polarity} = {i[1], i[2]};
			restart(c);
			offer(3, k);
			repeat (1400) @(posedge mclk);
			chk(txq.size() == 0 && k == 3, "words sent");
			if (i[0])
				chk(lat == l0 + sport_pkg::OE_EXTRA_CYC, "enable delay");
			l0 = lat;
			$display("test transfer %0d done", i);
		end
		// External clocks and syncs: fill while stalled, drain, then underrun.
		for (int i = 0; i < 2; i++)
		begin
			c = '0;
			c.tx_first_bit_delay = 2'(i);
			c.rx_first_bit_delay = 2'h1;
			c.out_enable_extra_delay = i[0];
			restart(c);
			offer(sport_pkg::FIFO_DEPTH + 4, k);
			chk(k == sport_pkg::FIFO_DEPTH && tx_word_ready === 1'b0, "buffer full");
			run <= 1'b1;
			repeat (12000) @(posedge mclk);
			chk(txq.size() == 0 && n_und > 0 && dout_oe === 1'b0, "drain and underrun");
			$display("test external %0d done", i);
		end
		conclude();
	end
endmodule
`default_nettype wire
